/* File: design/lcd_instr_pkg.sv */
package lcd_instr_pkg;

   // ==========================================
   // Timing
   // ==========================================
   localparam int CLK_MHZ          = 100;
   localparam int LONG_EXEC_US_X100 = 152000;
   localparam int SHORT_EXEC_NS    = 37000;
   localparam int LONG_EXEC_CYC    = LONG_EXEC_US_X100 / 10;
   localparam int SHORT_EXEC_CYC   = SHORT_EXEC_NS * CLK_MHZ / 1000;

   // ==========================================
   // Address ranges
   // ==========================================
   localparam logic [6:0] ONE_LINE_LAST  = 7'h4f;
   localparam logic [6:0] TWO_LINE_LAST  = 7'h27;
   localparam logic [6:0] FOUR_LINE_LAST = 7'h13;
   localparam logic [6:0] LINE_SPAN      = 7'h20;
   localparam logic [6:0] SECOND_HALF    = 7'h40;
   localparam logic [5:0] MAX_SCROLL     = 6'h30;
   localparam logic [6:0] CODE_RAM_DEPTH = 7'h74;
   localparam int         GLYPH_DEPTH    = 64;
   localparam int         ICON_DEPTH     = 16;

   // ==========================================
   // Reset values
   // ==========================================
   localparam logic RST_BUS_WIDTH = 1'b1;
   localparam logic RST_STEP_DIR  = 1'b1;

   typedef enum logic [1:0] {
      RAM_CODE,
      RAM_GLYPH,
      RAM_ICON
   } ram_sel_t;

   typedef enum logic [1:0] {
      S_IDLE,
      S_BUSY,
      S_CLEAR
   } exec_state_t;

   typedef struct packed {
      logic panelOn;
      logic pointerMarkOn;
      logic glyphFlash;
      logic wideFont;
      logic invertMark;
      logic fourRowSel;
      logic busWidthSel;
      logic twoRowSel;
      logic glyphFlicker;
      logic lowPowerSel;
      logic stepDirection;
      logic windowFollow;
   } mode_bits_t;

   typedef struct packed {
      logic       valid;
      logic       regSelect;
      logic       readNotWrite;
      logic [7:0] data;
   } host_req_t;

endpackage

/* File: design/lcd_instruction_decoder.sv */
// Functional notes
// RULE_01: Code address set only when bank locked
// RULE_02: Code addresses valid per line mode
// RULE_03: Scroll count writable only when unlocked
// RULE_04: Scroll decode: 0 none, 1-47, 48 cap
// RULE_05: Low power blocks display shift, scroll
// RULE_06: Busy read returns flag and address
// RULE_07: Host polls busy before each write
// RULE_08: Data write goes to selected RAM
// RULE_09: Write steps address by entry direction
// RULE_10: Data read from selected RAM
// RULE_11: Read steps address, never shifts display
// RULE_12: Read after write returns stale data
// RULE_13: Clear blanks RAM, address zero, long
// RULE_14: Home zeroes address, cancels shift
// RULE_15: Entry mode sets direction and follow
// RULE_16: Locked display control sets three bits
// RULE_17: Unlocked opcode sets font, invert, rows
// RULE_18: Locked move shifts cursor or display
// RULE_19: Unlocked move opcode sets line scroll
// RULE_20: Function set, extended bits when unlocked
// RULE_21: Locked glyph address set
// RULE_22: Unlocked icon address set
// RULE_23: Locked bank keeps extended values
module lcd_instruction_decoder
   import lcd_instr_pkg::*;
#(
   parameter int LONG_CYC  = LONG_EXEC_CYC,
   parameter int SHORT_CYC = SHORT_EXEC_CYC
) (
   input  wire logic       core_clk,
   input  wire logic       arst_n,
   input  wire logic       clkEn,
   input  wire host_req_t  hostReq,
   input  wire logic       expanderPin,
   output logic [7:0]      readData,
   output logic            readValid,
   output logic            busyIndicator,
   output logic [6:0]      addrCounter,
   output logic            bankUnlock,
   output mode_bits_t      modeBits,
   output logic [3:0]      lineScrollSel,
   output logic [5:0]      scrollDots,
   output logic [6:0]      displayShift,
   output logic            lowPowerActive
);

   // Clear sweeps the code RAM inside the long count, so it must outlast it
   if (LONG_CYC <= int'(CODE_RAM_DEPTH) || SHORT_CYC < 2 || SHORT_CYC > LONG_CYC) begin : g_bad
      $error("Execution counts out of range");
   end

   // ==========================================
   // State
   // ==========================================
   logic [7:0]  codeRam [CODE_RAM_DEPTH];
   logic [7:0]  glyphRam [GLYPH_DEPTH];
   logic [7:0]  iconRam [ICON_DEPTH];
   ram_sel_t    ramSel;
   exec_state_t state;
   logic [31:0] busyCount;
   logic [6:0]  clearAddr;
   logic        expStable;
   logic [5:0]  scrollDotCount;
   logic        addrSetSeen;
   logic [2:0]  expSync;

   // ==========================================
   // Decode
   // ==========================================
   // Accept also waits out the flag's trailing cycle so the host never sees it lie
   wire logic accept   = clkEn && hostReq.valid && (state == S_IDLE) && !busyIndicator;
   wire logic cmdWr    = accept && !hostReq.regSelect && !hostReq.readNotWrite;
   // Busy polls are answered on any cycle with clkEn high, busy or not
   wire logic busyRd   = clkEn && hostReq.valid && !hostReq.regSelect && hostReq.readNotWrite;
   wire logic dataWr   = accept && hostReq.regSelect && !hostReq.readNotWrite;
   wire logic dataRd   = accept && hostReq.regSelect && hostReq.readNotWrite;
   wire logic [7:0] d  = hostReq.data;
   wire logic opClear  = cmdWr && d == 8'h01;
   wire logic opHome   = cmdWr && d[7:1] == 7'h01;
   wire logic opEntry  = cmdWr && d[7:2] == 6'h01;
   wire logic opDisp   = cmdWr && d[7:3] == 5'h01;
   wire logic opMove   = cmdWr && d[7:4] == 4'h1;
   wire logic opFunc   = cmdWr && d[7:5] == 3'h1;
   wire logic opRamA   = cmdWr && d[7:6] == 2'h1;
   wire logic opCodeA  = cmdWr && d[7];
   wire logic opScroll = cmdWr && d[7:6] == 2'h2 && bankUnlock; // RULE_03
   wire logic opCodeOk = opCodeA && !bankUnlock; // RULE_01
   wire logic lpActive = modeBits.lowPowerSel && !expStable; // RULE_20
   wire logic shiftOk  = !lpActive; // RULE_05
   wire logic moveDisp = opMove && !bankUnlock && d[3];
   wire logic [6:0] stepAddr = modeBits.stepDirection ? addrCounter + 7'h01
                                                      : addrCounter - 7'h01;
   wire logic [6:0] codeLast = modeBits.fourRowSel ? FOUR_LINE_LAST :
                               modeBits.twoRowSel  ? TWO_LINE_LAST  : ONE_LINE_LAST;
   // RULE_02
   wire logic [6:0] inLine = modeBits.fourRowSel ? (addrCounter & 7'h1f) :
                             modeBits.twoRowSel ? (addrCounter & 7'h3f) : addrCounter;
   wire logic codeAddrOk = inLine <= codeLast;
   wire logic [7:0] ramWord = (ramSel == RAM_GLYPH) ? glyphRam[addrCounter[5:0]] :
                              (ramSel == RAM_ICON)  ? iconRam[addrCounter[3:0]] :
                              (codeAddrOk ? codeRam[addrCounter] : 8'h00);
   // RULE_04
   wire logic [5:0] dotsDecoded = (scrollDotCount[5:4] == 2'b11) ? MAX_SCROLL
                                                                 : scrollDotCount;
   wire logic [31:0] execLen = (opClear || opHome) ? LONG_CYC : SHORT_CYC;

   // ==========================================
   // Pin synchroniser
   // ==========================================
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         expSync   <= 3'b000;
         expStable <= 1'b0;
      end else if (clkEn) begin
         expSync <= {expSync[1:0], expanderPin};
         // Level only moves once the two late stages agree
         if (expSync[1] == expSync[2]) begin
            expStable <= expSync[2];
         end
      end
   end

   // ==========================================
   // Execution timer
   // ==========================================
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state     <= S_IDLE;
         busyCount <= 32'h0;
         clearAddr <= 7'h00;
      end else if (clkEn) begin
         case (state)
            S_IDLE: begin
               if (cmdWr || dataWr || dataRd) begin // RULE_06
                  state     <= opClear ? S_CLEAR : S_BUSY;
                  busyCount <= execLen - 32'h1;
                  clearAddr <= 7'h00;
               end
            end
            S_CLEAR: begin // RULE_13
               if (clearAddr == CODE_RAM_DEPTH - 7'h01) begin
                  state <= S_BUSY;
               end
               clearAddr <= clearAddr + 7'h01;
               busyCount <= busyCount - 32'h1;
            end
            S_BUSY: begin
               if (busyCount <= 32'h1) begin
                  state <= S_IDLE;
               end
               busyCount <= busyCount - 32'h1;
            end
            default: state <= S_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (clkEn) begin
         if (state == S_CLEAR) begin
            codeRam[clearAddr] <= 8'h20;
         end else if (dataWr && ramSel == RAM_CODE && codeAddrOk) begin // RULE_08
            codeRam[addrCounter] <= d;
         end
         if (dataWr && ramSel == RAM_GLYPH) begin
            glyphRam[addrCounter[5:0]] <= d;
         end
         if (dataWr && ramSel == RAM_ICON) begin
            iconRam[addrCounter[3:0]] <= d;
         end
      end
   end

   // ==========================================
   // Address counter and mode registers
   // ==========================================
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         addrCounter   <= 7'h00;
         ramSel        <= RAM_CODE;
         bankUnlock    <= 1'b0;
         modeBits      <= '0;
         modeBits.busWidthSel   <= RST_BUS_WIDTH;
         modeBits.stepDirection <= RST_STEP_DIR;
         lineScrollSel <= 4'h0;
         scrollDotCount <= 6'h00;
         displayShift  <= 7'h00;
         addrSetSeen   <= 1'b0;
      end else if (clkEn) begin
         if (opClear || opHome) begin // RULE_13 RULE_14
            addrCounter  <= 7'h00;
            ramSel       <= RAM_CODE;
            displayShift <= 7'h00;
         end else if (opEntry) begin // RULE_15
            modeBits.stepDirection <= d[1];
            modeBits.windowFollow  <= d[0];
         end else if (opDisp && !bankUnlock) begin // RULE_16 RULE_23
            modeBits.panelOn       <= d[2];
            modeBits.pointerMarkOn <= d[1];
            modeBits.glyphFlash    <= d[0];
         end else if (opDisp) begin // RULE_17
            modeBits.wideFont   <= d[2];
            modeBits.invertMark <= d[1];
            modeBits.fourRowSel <= d[0];
         end else if (opMove && !bankUnlock) begin // RULE_18
            if (moveDisp) begin
               if (shiftOk) begin
                  displayShift <= d[2] ? displayShift + 7'h01 : displayShift - 7'h01;
               end
            end else begin
               addrCounter <= d[2] ? addrCounter + 7'h01 : addrCounter - 7'h01;
            end
         end else if (opMove) begin // RULE_19
            lineScrollSel <= d[3:0];
         end else if (opFunc) begin // RULE_20
            modeBits.busWidthSel <= d[4];
            modeBits.twoRowSel   <= d[3];
            bankUnlock           <= d[2];
            if (bankUnlock) begin
               modeBits.glyphFlicker <= d[1];
               modeBits.lowPowerSel  <= d[0];
            end
         end else if (opRamA && !bankUnlock) begin // RULE_21
            addrCounter <= {1'b0, d[5:0]};
            ramSel      <= RAM_GLYPH;
            addrSetSeen <= 1'b1;
         end else if (opRamA) begin // RULE_22
            addrCounter <= {3'b000, d[3:0]};
            ramSel      <= RAM_ICON;
            addrSetSeen <= 1'b1;
         end else if (opScroll) begin // RULE_03
            scrollDotCount <= d[5:0];
         end else if (opCodeOk) begin // RULE_01
            addrCounter <= d[6:0];
            ramSel      <= RAM_CODE;
            addrSetSeen <= 1'b1;
         end else if (dataWr) begin // RULE_09 RULE_12
            addrCounter <= stepAddr;
            if (modeBits.windowFollow && ramSel == RAM_CODE && shiftOk) begin
               displayShift <= modeBits.stepDirection ? displayShift + 7'h01
                                                      : displayShift - 7'h01;
            end
         end else if (dataRd) begin // RULE_10 RULE_11
            addrCounter <= stepAddr;
         end
      end
   end

   // ==========================================
   // Outputs
   // ==========================================
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         readData       <= 8'h00;
         readValid      <= 1'b0;
         busyIndicator  <= 1'b0;
         scrollDots     <= 6'h00;
         lowPowerActive <= 1'b0;
      end else if (clkEn) begin
         readValid <= busyRd || dataRd;
         if (busyRd) begin // RULE_06
            readData <= {busyIndicator || (state != S_IDLE), addrCounter};
         end else if (dataRd) begin
            readData <= addrSetSeen ? ramWord : 8'h00;
         end
         busyIndicator  <= (state != S_IDLE) || cmdWr || dataWr || dataRd;
         scrollDots     <= shiftOk ? dotsDecoded : 6'h00; // RULE_04 RULE_05
         lowPowerActive <= lpActive;
      end
   end

   // ==========================================
   // Checks
   // ==========================================
   busy_blocks_a: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE_06
      (state != S_IDLE) |-> busyIndicator && !accept)
      else $error("Request accepted while busy");
   clear_addr_a: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE_13
      opClear |=> addrCounter == 7'h00 && displayShift == 7'h00)
      else $error("Clear did not reset address");
   scroll_lock_a: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE_03
      (cmdWr && !bankUnlock) |=> $stable(scrollDotCount))
      else $error("Scroll count changed while locked");
   scroll_cap_a: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE_04
      scrollDots <= MAX_SCROLL)
      else $error("Scroll exceeds cap");
   lowpow_shift_a: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE_05
      (clkEn && lpActive && !opClear && !opHome) |=> $stable(displayShift))
      else $error("Display shifted in low power");
   read_noshift_a: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE_11
      dataRd |=> $stable(displayShift))
      else $error("Read shifted display");
   ext_hold_a: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE_23
      (opDisp && !bankUnlock) |=> $stable(modeBits.wideFont))
      else $error("Extended bit changed while locked");
   write_step_a: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE_09
      (dataWr && modeBits.stepDirection) |=> addrCounter == $past(addrCounter) + 7'h01)
      else $error("Write did not step address");
   busy_read_a: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE_06
      busyRd |=> readValid && readData[6:0] == $past(addrCounter))
      else $error("Busy read did not return address");

endmodule

/* File: verif/host_model.sv */
module host_model
   import lcd_instr_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       busyIndicator,
   input  wire logic       readValid,
   input  wire logic [7:0] readData,
   output host_req_t       hostReq
);
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================
   // Bus cycles
   // ==========================================
   task automatic wait_idle();
      int n;
      n = 0;
      while (busyIndicator !== 1'b0 && n < 20000) begin
         @(negedge core_clk);
         n++;
      end
   endtask

   // Taken at the next edge; read data is registered on that same edge
   task automatic xfer(input logic rs, input logic rnw, input logic [7:0] d,
                       output logic [7:0] q);
      @(negedge core_clk);
      hostReq <= '{valid: 1'b1, regSelect: rs, readNotWrite: rnw, data: d};
      @(negedge core_clk);
      q = readData;
      // Released lines show the inverse, never the stale byte
      hostReq <= '{valid: 1'b0, regSelect: ~rs, readNotWrite: ~rnw, data: ~d};
   endtask

   // Busy flag must read clear before every access
   task automatic access(input logic rs, input logic rnw, input logic [7:0] d,
                         output logic [7:0] q);
      logic [7:0] st;
      st = 8'h80;
      while (st[7] !== 1'b0) begin
         wait_idle();
         xfer(1'b0, 1'b1, 8'h00, st);
      end
      xfer(rs, rnw, d, q);
   endtask

   initial hostReq = '0;
endmodule

/* File: verif/tb_top.sv */
module tb_top
   import lcd_instr_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;

   logic       core_clk;
   logic       arst_n;
   logic       clkEn;
   logic       expanderPin;
   host_req_t  hostReq;
   logic [7:0] readData;
   logic       readValid;
   logic       busyIndicator;
   logic [6:0] addrCounter;
   logic       bankUnlock;
   mode_bits_t modeBits;
   logic [3:0] lineScrollSel;
   logic [5:0] scrollDots;
   logic [6:0] displayShift;
   logic       lowPowerActive;
   logic [7:0] q;
   int         mismatches;
   int         checkCount;

   // Short busy counts keep the run brief
   lcd_instruction_decoder #(.LONG_CYC(200), .SHORT_CYC(10)) dut (
      .core_clk(core_clk), .arst_n(arst_n), .clkEn(clkEn), .hostReq(hostReq),
      .expanderPin(expanderPin), .readData(readData), .readValid(readValid),
      .busyIndicator(busyIndicator), .addrCounter(addrCounter),
      .bankUnlock(bankUnlock), .modeBits(modeBits), .lineScrollSel(lineScrollSel),
      .scrollDots(scrollDots), .displayShift(displayShift),
      .lowPowerActive(lowPowerActive));

   host_model host (
      .core_clk(core_clk), .busyIndicator(busyIndicator), .readValid(readValid),
      .readData(readData), .hostReq(hostReq));

   // ==========================================
   // Helpers
   // ==========================================
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checkCount++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmd(input logic [7:0] c);
      host.access(1'b0, 1'b0, c, q);
   endtask
   task automatic wr(input logic [7:0] d);
      host.access(1'b1, 1'b0, d, q);
   endtask
   task automatic rd();
      host.access(1'b1, 1'b1, 8'h00, q);
   endtask
   task automatic report_and_stop();
      $display("checks=%0d mismatches=%0d", checkCount, mismatches);
      if (mismatches == 0 && checkCount > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // ==========================================
   // Scenarios
   // ==========================================
   task automatic t_reset();
      chk(busyIndicator, 1'b0);
      chk(addrCounter, 7'h00);
      chk({bankUnlock, modeBits.busWidthSel, modeBits.stepDirection}, 3'b011);
      $display("reset test done");
   endtask

   task automatic t_code_rw();
      cmd(8'h85);
      chk(addrCounter, 7'h05);
      wr(8'ha5);
      chk(addrCounter, 7'h06);
      cmd(8'h85);
      rd();
      chk(q, 8'ha5);
      chk(readValid, 1'b1);
      chk(addrCounter, 7'h06);
      cmd(8'h05);
      chk(modeBits.stepDirection, 1'b0);
      rd();
      chk(addrCounter, 7'h05);
      chk(displayShift, 7'h00);
      wr(8'h3c);
      chk(addrCounter, 7'h04);
      cmd(8'h02);
      cmd(8'h06);
      $display("code ram test done");
   endtask

   task automatic t_busy();
      cmd(8'h90);
      chk(busyIndicator, 1'b1);
      // Offered while busy: must be dropped
      host.xfer(1'b0, 1'b0, 8'h81, q);
      chk(addrCounter, 7'h10);
      host.xfer(1'b0, 1'b1, 8'h00, q);
      chk(q, 8'h90);
      host.wait_idle();
      host.xfer(1'b0, 1'b1, 8'h00, q);
      chk(q, 8'h10);
      $display("busy test done");
   endtask

   task automatic t_ext();
      logic [5:0] v[5] = '{6'h00, 6'h01, 6'h2f, 6'h30, 6'h3f};
      logic [5:0] e[5] = '{6'd0, 6'd1, 6'd47, 6'd48, 6'd48};
      cmd(8'h0f);
      chk({modeBits.panelOn, modeBits.pointerMarkOn, modeBits.glyphFlash}, 3'b111);
      cmd(8'h36);
      // Flicker bit lands only once the bank was already open
      chk({bankUnlock, modeBits.glyphFlicker}, 2'b10);
      cmd(8'h36);
      chk({bankUnlock, modeBits.glyphFlicker}, 2'b11);
      cmd(8'h0b);
      chk({modeBits.wideFont, modeBits.invertMark, modeBits.fourRowSel}, 3'b011);
      cmd(8'h1a);
      chk(lineScrollSel, 4'ha);
      for (int i = 0; i < 5; i++) begin
         cmd({2'b10, v[i]});
         // Decoded shift is registered a cycle after the count
         @(negedge core_clk);
         chk(scrollDots, e[i]);
      end
      cmd(8'h43);
      chk(addrCounter, 7'h03);
      wr(8'h5a);
      cmd(8'h43);
      rd();
      chk(q, 8'h5a);
      cmd(8'h30);
      chk(bankUnlock, 1'b0);
      cmd(8'h0b);
      chk({modeBits.panelOn, modeBits.pointerMarkOn, modeBits.glyphFlash}, 3'b011);
      chk({modeBits.wideFont, modeBits.invertMark, modeBits.fourRowSel}, 3'b011);
      // Would load a count of 5 if the locked bank let it through
      cmd(8'h85);
      chk(addrCounter, 7'h05);
      @(negedge core_clk);
      chk(scrollDots, 6'd48);
      $display("extended bank test done");
   endtask

   task automatic t_glyph_range();
      cmd(8'h55);
      chk(addrCounter, 7'h15);
      wr(8'hc3);
      cmd(8'h55);
      rd();
      chk(q, 8'hc3);
      // Four-row mode: 0x38 falls in the gap between rows
      cmd(8'hb8);
      wr(8'h77);
      cmd(8'hb8);
      rd();
      chk(q, 8'h00);
      cmd(8'he0);
      wr(8'h11);
      cmd(8'he0);
      rd();
      chk(q, 8'h11);
      $display("glyph and range test done");
   endtask

   task automatic t_shift_clear();
      cmd(8'h85);
      cmd(8'h14);
      chk(addrCounter, 7'h06);
      cmd(8'h18);
      chk(addrCounter, 7'h06);
      chk(displayShift !== 7'h00, 1'b1);
      cmd(8'h02);
      chk({displayShift, 1'b0} | addrCounter, 8'h00);
      cmd(8'h01);
      chk({busyIndicator, addrCounter}, 8'h80);
      cmd(8'h85);
      rd();
      chk(q, 8'h20);
      $display("shift and clear test done");
   endtask

   task automatic t_freeze();
      host.wait_idle();
      clkEn = 1'b0;
      host.xfer(1'b0, 1'b0, 8'h8a, q);
      chk({busyIndicator, addrCounter}, 8'h06);
      clkEn = 1'b1;
      $display("clock enable test done");
   endtask

   task automatic t_low_power();
      // First pass opens the bank, second stores the low-power bit
      cmd(8'h35);
      cmd(8'h35);
      chk(lowPowerActive, 1'b0);
      expanderPin = 1'b0;
      repeat (6) @(negedge core_clk);
      chk({lowPowerActive, scrollDots}, 7'h40);
      // Lock the bank but keep low power set
      cmd(8'h31);
      cmd(8'h18);
      chk(displayShift, 7'h00);
      $display("low power test done");
   endtask

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   initial begin
      arst_n = 1'b0;
      expanderPin = 1'b1;
      clkEn = 1'b1;
      mismatches = 0;
      checkCount = 0;
      repeat (12) @(negedge core_clk);
      arst_n = 1'b1;
      t_reset();
      t_code_rw();
      t_busy();
      t_ext();
      t_glyph_range();
      t_shift_clear();
      t_freeze();
      t_low_power();
      report_and_stop();
   end

   // Full run needs well under two thousand cycles; this bound is generous
   initial begin
      #500us;
      mismatches++;
      report_and_stop();
   end
endmodule
